// ---- inc/smr_consts.svh ----
// Function
// - low-voltage detection works only while its enable bit is set.
// - detect trip level select bit picks high or low detect level.
// - any stop mode switches detection off unless stop-mode detect enable is set.
// - detect enable plus stop-mode enable refuses the two deepest stop modes.
// - power-on sets power-on and low-voltage status, holds reset above low level.
// - detect reset enable makes a low supply reset and hold until above level.
// - enabled detection with interrupt and without reset sets flag and requests interrupt.
// - warning flag sets when supply nears detect level; never interrupts.
// - warning level select bit picks high or low warning level.
// - periodic timer clock is internal 1 kHz or external reference.
// - deep stop wake-up by periodic timer only with internal clock selected.
// - timer register holds read-only flag, write-only ack, 3-bit period select.
// - periodic interrupt reaches the CPU only while its enable is set.
// - period select of zero stops the timer; no periodic interrupts.
// - bit 6 read/write; 1 disables pin pull-up while pin function enabled.
// - bit 4 enables the request pin as interrupt input.
// - bit 3 read-only flag set on a detected pin event.
// - bit 2 write-only; 1 clears pin flag, 0 ignored, reads zero.
// - in edge-and-level mode ack cannot clear flag while pin stays low.
// - bit 1 enables pin interrupt whenever pin flag is one.
// - bit 0 selects falling edge only or falling edge and low level.
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH

`define SMR_ADDR_LVD1   3'h0
`define SMR_ADDR_LVD3   3'h1
`define SMR_ADDR_RTI    3'h2
`define SMR_ADDR_PIN    3'h3
`define SMR_ADDR_RST    3'h4

`define SMR_B_FLAG      7
`define SMR_B_ACK       6
`define SMR_B_LVD_IE    5
`define SMR_B_LVD_RE    4
`define SMR_B_LVD_SE    3
`define SMR_B_LVD_EN    2
`define SMR_B_DET_LVL   5
`define SMR_B_WARN_LVL  4
`define SMR_B_RTI_CS    5
`define SMR_B_RTI_IE    4
`define SMR_B_RTI_PH    2
`define SMR_B_RTI_PL    0
`define SMR_B_PIN_PDD   6
`define SMR_B_PIN_PE    4
`define SMR_B_PIN_F     3
`define SMR_B_PIN_ACK   2
`define SMR_B_PIN_IE    1
`define SMR_B_PIN_MOD   0
`define SMR_B_POR       7
`define SMR_B_LV        1

`define SMR_RST_LVD_EN  1'b1
`define SMR_RST_LVD_RE  1'b1
`define SMR_RST_PIN_N   1'b1

`define SMR_RTI_P1      11'h008
`define SMR_RTI_P2      11'h020
`define SMR_RTI_P3      11'h040
`define SMR_RTI_P4      11'h080
`define SMR_RTI_P5      11'h100
`define SMR_RTI_P6      11'h200
`define SMR_RTI_P7      11'h400

`endif

// ---- inc/smr_pkg.sv ----
package smr_pkg;

    typedef struct packed {
        logic int_en;
        logic rst_en;
        logic stop_en;
        logic det_en;
    } smr_lvd_ctrl_type;

    typedef struct packed {
        logic det_lvl_hi;
        logic warn_lvl_hi;
    } smr_lvl_ctrl_type;

    typedef struct packed {
        logic       clk_ext;
        logic       int_en;
        logic [2:0] period;
    } smr_rti_ctrl_type;

    typedef struct packed {
        logic pull_dis;
        logic pin_en;
        logic int_en;
        logic mode;
    } smr_pin_ctrl_type;

    typedef enum logic [1:0] {
        SMR_POR_HOLD,
        SMR_RUN,
        SMR_LVD_HOLD
    } smr_sup_state_type;

endpackage

// ---- rtl/smr_sync.sv ----
module smr_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // clock and control
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_ce,
    // data
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] meta;

    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
                meta[g] <= INIT[g];
                o_q[g]  <= INIT[g];
            end else if (i_ce) begin
                meta[g] <= i_d[g];
                o_q[g]  <= meta[g];
            end
        end
    end

endmodule

// ---- rtl/smr_rti_timer.sv ----
`include "smr_consts.svh"

module smr_rti_timer #(
    parameter logic [10:0] P1 = `SMR_RTI_P1,
    parameter logic [10:0] P2 = `SMR_RTI_P2,
    parameter logic [10:0] P3 = `SMR_RTI_P3,
    parameter logic [10:0] P4 = `SMR_RTI_P4,
    parameter logic [10:0] P5 = `SMR_RTI_P5,
    parameter logic [10:0] P6 = `SMR_RTI_P6,
    parameter logic [10:0] P7 = `SMR_RTI_P7
) (
    // clock and control
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    // tick and period
    input  wire logic       i_tick,
    input  wire logic [2:0] i_period,
    output logic            o_event
);

    function automatic logic [10:0] limit(input logic [2:0] s);
        case (s)
            3'h1:    limit = P1;
            3'h2:    limit = P2;
            3'h3:    limit = P3;
            3'h4:    limit = P4;
            3'h5:    limit = P5;
            3'h6:    limit = P6;
            3'h7:    limit = P7;
            default: limit = 11'h000;
        endcase
    endfunction

    logic [10:0] count;
    wire  [10:0] lim     = limit(i_period);
    wire         stopped = (lim == 11'h000);
    wire         at_end  = (count >= lim - 11'h001);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            count   <= 11'h000;
            o_event <= 1'b0;
        end else if (i_ce) begin
            o_event <= 1'b0;
            if (stopped) begin
                count <= 11'h000;
            end else if (i_tick && at_end) begin
                count   <= 11'h000;
                o_event <= 1'b1;
            end else if (i_tick) begin
                count <= count + 11'h001;
            end
        end
    end

endmodule

// ---- rtl/smr_top.sv ----
// Chosen here: the register offsets and the strobed register port.
`include "smr_consts.svh"

module smr_top
    import smr_pkg::*;
(
    // clock, reset, enable
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    // register port
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // supply comparators, high means supply below level
    input  wire logic       i_below_det_hi,
    input  wire logic       i_below_det_lo,
    input  wire logic       i_below_warn_hi,
    input  wire logic       i_below_warn_lo,
    // request pin and timer clocks
    input  wire logic       i_req_pin_n,
    input  wire logic       i_tick_1k,
    input  wire logic       i_ext_ref,
    // power mode
    input  wire logic       i_stop_active,
    input  wire logic       i_stop_deep,
    // to cpu and power control
    output logic            o_sys_reset,
    output logic            o_lvd_irq,
    output logic            o_rti_irq,
    output logic            o_pin_irq,
    output logic            o_rti_wake,
    output logic            o_deep_stop_block,
    output logic            o_pin_pull_en
);

    function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
        hit = (a == off);
    endfunction

    smr_lvd_ctrl_type  lvd;
    smr_lvl_ctrl_type  lvl;
    smr_rti_ctrl_type  rti;
    smr_pin_ctrl_type  pin;
    smr_sup_state_type state;
    smr_sup_state_type next_state;
    logic              det_flag;
    logic              warn_flag;
    logic              rti_flag;
    logic              pin_flag;
    logic              por_stat;
    logic              lv_stat;
    logic              pin_q;
    logic              tick_q;
    logic              ext_q;
    logic              rti_event;
    logic [4:0]        sync_in;
    logic [7:0]        rd_word;

    // comparator and request pin inputs first pass a two-stage synchroniser; timer clocks go straight to edge detection
    // comparators reset to below, else power-on hold drops for two cycles
    smr_sync #(
        .WIDTH (5),
        .INIT  ({`SMR_RST_PIN_N, 4'hF})
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .i_d     ({i_req_pin_n, i_below_det_hi, i_below_det_lo,
                   i_below_warn_hi, i_below_warn_lo}),
        .o_q     (sync_in)
    );

    wire pin_n   = sync_in[4];
    wire det_hi  = sync_in[3];
    wire det_lo  = sync_in[2];
    wire warn_hi = sync_in[1];
    wire warn_lo = sync_in[0];

    // address decode
    wire wr_lvd1 = i_wr && hit(i_addr, `SMR_ADDR_LVD1);
    wire wr_lvd3 = i_wr && hit(i_addr, `SMR_ADDR_LVD3);
    wire wr_rti  = i_wr && hit(i_addr, `SMR_ADDR_RTI);
    wire wr_pin  = i_wr && hit(i_addr, `SMR_ADDR_PIN);
    wire rd_pin  = i_rd && hit(i_addr, `SMR_ADDR_PIN);
    wire running = (state == SMR_RUN);

    // supply detection
    wire below_det  = lvl.det_lvl_hi ? det_hi : det_lo;
    wire below_warn = lvl.warn_lvl_hi ? warn_hi : warn_lo;
    wire det_active = lvd.det_en && (!i_stop_active || lvd.stop_en);
    wire lvd_trip   = det_active && below_det;
    wire lvd_rst    = lvd_trip && lvd.rst_en;
    wire det_set    = lvd_trip && lvd.int_en && !lvd.rst_en;
    wire warn_set   = det_active && below_warn && !below_det;
    wire det_ack    = wr_lvd1 && i_wdata[`SMR_B_ACK];
    wire warn_ack   = wr_lvd3 && i_wdata[`SMR_B_ACK];

    // request pin event detection
    wire pin_low  = pin.pin_en && !pin_n;
    wire pin_fall = pin_low && pin_q;
    wire pin_set  = pin_fall || (pin.mode && pin_low);
    wire pin_ack  = wr_pin && i_wdata[`SMR_B_PIN_ACK];

    // periodic timer source
    wire int_rise = i_tick_1k && !tick_q;
    wire ext_rise = i_ext_ref && !ext_q;
    wire rti_tick = rti.clk_ext ? ext_rise : int_rise;
    wire rti_ack  = wr_rti && i_wdata[`SMR_B_ACK];

    // flag next values: a set in the same cycle as an ack wins
    wire next_det_flag  = det_set || (det_flag && !det_ack);
    wire next_warn_flag = warn_set || (warn_flag && !warn_ack);
    wire next_rti_flag  = rti_event || (rti_flag && !rti_ack);
    wire next_pin_flag  = pin_set || (pin_flag && !pin_ack);

    // outputs, all registered
    wire next_sys_reset   = (next_state != SMR_RUN);
    wire next_lvd_irq     = det_flag && lvd.int_en;
    wire next_rti_irq     = rti_flag && rti.int_en;
    wire next_pin_irq     = pin_flag && pin.int_en;
    wire next_deep_block  = lvd.det_en && lvd.stop_en;
    wire next_pull_en     = pin.pin_en && !pin.pull_dis;
    wire next_rti_wake    = rti_event && rti.int_en && i_stop_active &&
                            (!i_stop_deep || !rti.clk_ext);
    wire [7:0] next_rdata = i_rd ? rd_word : 8'h00;

    smr_rti_timer u_rti (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_ce     (i_ce),
        .i_tick   (rti_tick),
        .i_period (rti.period),
        .o_event  (rti_event)
    );

    // supply state
    always_comb begin
        next_state = state;
        case (state)
            SMR_POR_HOLD: begin
                if (!det_lo) begin
                    next_state = SMR_RUN;
                end
            end
            SMR_RUN: begin
                if (lvd_rst) begin
                    next_state = SMR_LVD_HOLD;
                end
            end
            SMR_LVD_HOLD: begin
                if (!below_det) begin
                    next_state = SMR_RUN;
                end
            end
            default: next_state = SMR_POR_HOLD;
        endcase
    end

    // read mux; reserved and write-only bits read zero
    always_comb begin
        rd_word = 8'h00;
        case (i_addr)
            `SMR_ADDR_LVD1: begin
                rd_word[`SMR_B_FLAG]   = det_flag;
                rd_word[`SMR_B_LVD_IE] = lvd.int_en;
                rd_word[`SMR_B_LVD_RE] = lvd.rst_en;
                rd_word[`SMR_B_LVD_SE] = lvd.stop_en;
                rd_word[`SMR_B_LVD_EN] = lvd.det_en;
            end
            `SMR_ADDR_LVD3: begin
                rd_word[`SMR_B_FLAG]     = warn_flag;
                rd_word[`SMR_B_DET_LVL]  = lvl.det_lvl_hi;
                rd_word[`SMR_B_WARN_LVL] = lvl.warn_lvl_hi;
            end
            `SMR_ADDR_RTI: begin
                rd_word[`SMR_B_FLAG]   = rti_flag;
                rd_word[`SMR_B_RTI_CS] = rti.clk_ext;
                rd_word[`SMR_B_RTI_IE] = rti.int_en;
                rd_word[`SMR_B_RTI_PH:`SMR_B_RTI_PL] = rti.period;
            end
            `SMR_ADDR_PIN: begin
                rd_word[`SMR_B_PIN_PDD] = pin.pull_dis;
                rd_word[`SMR_B_PIN_PE]  = pin.pin_en;
                rd_word[`SMR_B_PIN_F]   = pin_flag;
                rd_word[`SMR_B_PIN_IE]  = pin.int_en;
                rd_word[`SMR_B_PIN_MOD] = pin.mode;
            end
            `SMR_ADDR_RST: begin
                rd_word[`SMR_B_POR] = por_stat;
                rd_word[`SMR_B_LV]  = lv_stat;
            end
            default: rd_word = 8'h00;
        endcase
    end

    // detect control returns to defaults while any reset is held
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lvd <= '{1'b0, `SMR_RST_LVD_RE, 1'b0, `SMR_RST_LVD_EN};
        end else if (i_ce && !running) begin
            lvd <= '{1'b0, `SMR_RST_LVD_RE, 1'b0, `SMR_RST_LVD_EN};
        end else if (i_ce && wr_lvd1) begin
            lvd <= '{i_wdata[`SMR_B_LVD_IE], i_wdata[`SMR_B_LVD_RE],
                     i_wdata[`SMR_B_LVD_SE], i_wdata[`SMR_B_LVD_EN]};
        end
    end

    // trip levels survive a low-voltage reset, only power-on clears them
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lvl <= '0;
        end else if (i_ce && wr_lvd3) begin
            lvl <= '{i_wdata[`SMR_B_DET_LVL], i_wdata[`SMR_B_WARN_LVL]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rti <= '0;
            pin <= '0;
        end else if (i_ce) begin
            if (wr_rti) begin
                rti <= '{i_wdata[`SMR_B_RTI_CS], i_wdata[`SMR_B_RTI_IE],
                         i_wdata[`SMR_B_RTI_PH:`SMR_B_RTI_PL]};
            end
            if (wr_pin) begin
                pin <= '{i_wdata[`SMR_B_PIN_PDD], i_wdata[`SMR_B_PIN_PE],
                         i_wdata[`SMR_B_PIN_IE], i_wdata[`SMR_B_PIN_MOD]};
            end
        end
    end

    // flags and state
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state     <= SMR_POR_HOLD;
            det_flag  <= 1'b0;
            warn_flag <= 1'b0;
            rti_flag  <= 1'b0;
            pin_flag  <= 1'b0;
        end else if (i_ce) begin
            state     <= next_state;
            det_flag  <= running && next_det_flag;
            warn_flag <= running && next_warn_flag;
            rti_flag  <= next_rti_flag;
            pin_flag  <= next_pin_flag;
        end
    end

    // status: power-on sets both, a low-voltage reset sets its own
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            por_stat <= 1'b1;
            lv_stat  <= 1'b1;
        end else if (i_ce && running && lvd_rst) begin
            lv_stat <= 1'b1;
        end
    end

    // edge history; pin idles high
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_q  <= `SMR_RST_PIN_N;
            tick_q <= 1'b0;
            ext_q  <= 1'b0;
        end else if (i_ce) begin
            pin_q  <= pin_n;
            tick_q <= i_tick_1k;
            ext_q  <= i_ext_ref;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata           <= 8'h00;
            o_sys_reset       <= 1'b1;
            o_lvd_irq         <= 1'b0;
            o_rti_irq         <= 1'b0;
            o_pin_irq         <= 1'b0;
            o_rti_wake        <= 1'b0;
            o_deep_stop_block <= 1'b0;
            o_pin_pull_en     <= 1'b0;
        end else if (i_ce) begin
            o_rdata           <= next_rdata;
            o_sys_reset       <= next_sys_reset;
            o_lvd_irq         <= next_lvd_irq;
            o_rti_irq         <= next_rti_irq;
            o_pin_irq         <= next_pin_irq;
            o_rti_wake        <= next_rti_wake;
            o_deep_stop_block <= next_deep_block;
            o_pin_pull_en     <= next_pull_en;
        end
    end

    property p_no_lvd;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && running && !lvd.det_en && !det_flag |=> running && !det_flag;
    endproperty
    a_no_lvd: assert property (p_no_lvd) else $error("detection active while off");

    property p_stop_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && running && i_stop_active && !lvd.stop_en |=> running;
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("reset from stop detection");

    property p_block;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && lvd.det_en && lvd.stop_en |=> o_deep_stop_block;
    endproperty
    a_block: assert property (p_block) else $error("deep stop not blocked");

    property p_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        $past(i_ce) |-> o_sys_reset == (state != SMR_RUN);
    endproperty
    a_hold: assert property (p_hold) else $error("reset output wrong");

    property p_lvd_rst;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && running && lvd_rst |=> state == SMR_LVD_HOLD && lv_stat && o_sys_reset;
    endproperty
    a_lvd_rst: assert property (p_lvd_rst) else $error("low supply reset missed");

    property p_det_irq;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && running && det_set |=> det_flag;
    endproperty
    a_det_irq: assert property (p_det_irq) else $error("detect flag not set");

    property p_rti_mask;
        @(posedge i_clk) disable iff (!i_rst_n)
        $past(i_ce) && o_rti_irq |-> $past(rti.int_en);
    endproperty
    a_rti_mask: assert property (p_rti_mask) else $error("masked timer interrupt");

    property p_rti_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        $past(i_ce) && $past(rti.period) == 3'h0 |-> !rti_event;
    endproperty
    a_rti_off: assert property (p_rti_off) else $error("stopped timer fired");

    property p_wake;
        @(posedge i_clk) disable iff (!i_rst_n)
        $past(i_ce) && o_rti_wake && $past(i_stop_deep) |-> !$past(rti.clk_ext);
    endproperty
    a_wake: assert property (p_wake) else $error("deep wake on external clock");

    property p_pull;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && pin.pull_dis |=> !o_pin_pull_en;
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up not disabled");

    property p_pin_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !pin.pin_en && !pin_flag |=> !pin_flag;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("flag set with pin off");

    property p_edge;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && pin.pin_en && pin_q && !pin_n |=> pin_flag;
    endproperty
    a_edge: assert property (p_edge) else $error("falling edge missed");

    property p_ack;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && pin_ack && !pin_set |=> !pin_flag;
    endproperty
    a_ack: assert property (p_ack) else $error("ack did not clear flag");

    property p_ack_rd;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && rd_pin |=> !o_rdata[`SMR_B_PIN_ACK];
    endproperty
    a_ack_rd: assert property (p_ack_rd) else $error("ack bit read nonzero");

    property p_level;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && pin.pin_en && pin.mode && !pin_n |=> pin_flag;
    endproperty
    a_level: assert property (p_level) else $error("flag cleared while low");

    property p_pin_irq;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && pin_flag && pin.int_en |=> o_pin_irq;
    endproperty
    a_pin_irq: assert property (p_pin_irq) else $error("pin interrupt missing");

    property p_edge_only;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_ce && !pin.mode && !pin_q && !pin_flag |=> !pin_flag;
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("level set edge mode");

    property p_sync;
        @(posedge i_clk) disable iff (!i_rst_n)
        $past(i_ce) && $past(i_ce, 2) && $past(i_rst_n) && $past(i_rst_n, 2)
            |-> pin_n == $past(i_req_pin_n, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("pin not two-stage synced");

endmodule

// ---- test/smr_cpu_model.sv ----
module smr_cpu_model (
    // clock and requests from the bench
    input  wire logic i_clk,
    input  wire logic i_want_stop,
    input  wire logic i_want_deep,
    input  wire logic i_deep_block,
    // power mode shown to the device
    output logic      o_stop_active,
    output logic      o_stop_deep
);
    timeunit 1ns;
    timeprecision 1ps;
    // deep stop only when the device does not refuse it
    always @(posedge i_clk) begin
        o_stop_active <= i_want_stop;
        o_stop_deep   <= i_want_stop & i_want_deep & !i_deep_block;
    end
endmodule

// ---- test/testbench.sv ----
`define CHK(a, b) check((a) === (b), 8'(a), 8'(b))
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [2:0]  i_addr = 3'h0, tcnt = 3'h0;
    logic [7:0]  i_wdata = 8'h00, o_rdata;
    logic        det_hi = 1'b0, det_lo = 1'b1, warn_lo = 1'b0, pin_n = 1'b1;
    logic        want_stop = 1'b0, want_deep = 1'b0, wake_seen = 1'b0, ext_on = 1'b0;
    logic        ce = 1'b1;
    logic        stop_act, stop_deep, sys_rst, lvd_irq, rti_irq, pin_irq, wake, dblk, pull;
    logic [31:0] seed = 32'hC6E6;
    int          bad_count = 0, n_compared = 0;

    always #4 i_clk = ~i_clk;
    // tick stand-in: one rising edge every 8 cycles keeps periods short
    always @(posedge i_clk) tcnt <= tcnt + 3'h1;
    always @(posedge i_clk) if (wake) wake_seen <= 1'b1;

    smr_top smr_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_below_det_hi(det_hi), .i_below_det_lo(det_lo), .i_below_warn_hi(1'b0),
        .i_below_warn_lo(warn_lo), .i_req_pin_n(pin_n), .i_tick_1k(tcnt[2]),
        .i_ext_ref(tcnt[1] & ext_on), .i_stop_active(stop_act), .i_stop_deep(stop_deep),
        .o_sys_reset(sys_rst), .o_lvd_irq(lvd_irq), .o_rti_irq(rti_irq),
        .o_pin_irq(pin_irq), .o_rti_wake(wake), .o_deep_stop_block(dblk),
        .o_pin_pull_en(pull));
    smr_cpu_model smr_cpu_model_inst (.i_clk(i_clk), .i_want_stop(want_stop),
        .i_want_deep(want_deep), .i_deep_block(dblk), .o_stop_active(stop_act),
        .o_stop_deep(stop_deep));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // pin register image from {pull_dis, pin_en, int_en, mode} and flag
    function automatic logic [7:0] pe(input logic [3:0] c, input logic f);
        return {1'b0, c[3], 1'b0, c[2], f, 1'b0, c[1], c[0]};
    endfunction
    task automatic check(input logic ok, input logic [7:0] a, input logic [7:0] e);
        n_compared++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        `CHK(o_rdata, e);
        @(posedge i_clk);
    endtask
    task automatic summarize;
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #100000;
        bad_count++;
        summarize();
    end

    initial begin
        cy(20);
        i_rst_n <= 1'b1;
        cy(10);
        `CHK(sys_rst, 1'b1);
        det_lo <= 1'b0;
        cy(8);
        `CHK(sys_rst, 1'b0);
        rc(4, 8'h82);
        rc(0, 8'h14);
        det_lo <= 1'b1;
        cy(6);
        `CHK(sys_rst, 1'b1);
        det_lo <= 1'b0;
        cy(8);
        `CHK(sys_rst, 1'b0);
        rc(4, 8'h82);
        wr(1, 8'h20);
        det_hi <= 1'b1;
        cy(6);
        `CHK(sys_rst, 1'b1);
        det_hi <= 1'b0;
        cy(8);
        repeat (8) begin
            seed = xs(seed);
            wr(1, seed[7:0]);
            rc(1, seed[7:0] & 8'h30);
        end
        wr(1, 8'h00);
        warn_lo <= 1'b1;
        cy(6);
        rc(1, 8'h80);
        `CHK(lvd_irq, 1'b0);
        warn_lo <= 1'b0;
        cy(4);
        wr(1, 8'h40);
        rc(1, 8'h00);
        wr(0, 8'h24);
        det_lo <= 1'b1;
        cy(8);
        `CHK(lvd_irq, 1'b1);
        rc(0, 8'hA4);
        det_lo <= 1'b0;
        cy(4);
        wr(0, 8'h64);
        cy(2);
        rc(0, 8'h24);
        wr(0, 8'h20);
        det_lo <= 1'b1;
        cy(8);
        rc(0, 8'h20);
        want_stop <= 1'b1;
        wr(0, 8'h24);
        cy(8);
        rc(0, 8'h24);
        wr(0, 8'h2C);
        want_deep <= 1'b1;
        cy(8);
        rc(0, 8'hAC);
        `CHK({dblk, stop_deep}, 2'b10);
        det_lo <= 1'b0;
        wr(0, 8'h40);
        wr(2, 8'h11);
        cy(80);
        `CHK({wake_seen, rti_irq}, 2'b11);
        rc(2, 8'h91);
        want_stop <= 1'b0;
        wr(2, 8'h51);
        cy(2);
        rc(2, 8'h11);
        wr(2, 8'h01);
        cy(80);
        `CHK(rti_irq, 1'b0);
        rc(2, 8'h81);
        wr(2, 8'h40);
        cy(150);
        rc(2, 8'h00);
        wr(2, 8'h31);
        cy(100);
        rc(2, 8'h31);
        // reference kept running as software must arrange for stop
        ext_on <= 1'b1;
        cy(100);
        rc(2, 8'hB1);
        wr(3, 8'h12);
        cy(2);
        `CHK(pull, 1'b1);
        wr(3, 8'h52);
        cy(2);
        `CHK(pull, 1'b0);
        rc(3, pe(4'b1110, 1'b0));
        wr(3, 8'h12);
        pin_n <= 1'b0;
        cy(8);
        rc(3, pe(4'b0110, 1'b1));
        `CHK(pin_irq, 1'b1);
        wr(3, 8'h16);
        cy(2);
        rc(3, pe(4'b0110, 1'b0));
        pin_n <= 1'b1;
        wr(3, 8'h13);
        cy(4);
        pin_n <= 1'b0;
        cy(8);
        wr(3, 8'h17);
        cy(2);
        rc(3, pe(4'b0111, 1'b1));
        pin_n <= 1'b1;
        cy(4);
        wr(3, 8'h17);
        cy(2);
        rc(3, pe(4'b0111, 1'b0));
        wr(3, 8'h02);
        pin_n <= 1'b0;
        cy(8);
        rc(3, pe(4'b0010, 1'b0));
        `CHK(pin_irq, 1'b0);
        // clock enable low: this write must be lost
        ce <= 1'b0;
        wr(3, 8'h12);
        ce <= 1'b1;
        rc(3, pe(4'b0010, 1'b0));
        summarize();
    end
endmodule
